// File: hw/ildx_pkg.sv
/*
 Package for the index register load decoder: operand codes, opcode
 fields, condition codes, state counts and bus carriers.
 Assumes a single clock domain; no imports are made by users.
*/
package ildx_pkg;
  // Register operand codes
  localparam logic [2:0] REG_A = 3'h0;
  localparam logic [2:0] REG_B = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_D = 3'h3;
  localparam logic [2:0] REG_E = 3'h4;
  localparam logic [2:0] REG_H = 3'h5;
  localparam logic [2:0] REG_L = 3'h6;
  localparam logic [2:0] REG_M = 3'h7;
  // Opcode group and low field patterns
  localparam logic [1:0] GRP_LOAD = 2'h3;
  localparam logic [1:0] GRP_IMM = 2'h0;
  localparam logic [2:0] SRC_IMM = 3'h6;
  // Field positions inside an opcode byte
  localparam int DEST_LSB = 3;
  localparam int SRC_LSB = 0;
  localparam int GRP_LSB = 6;
  // Condition flag select codes
  localparam logic [1:0] COND_CARRY = 2'h0;
  localparam logic [1:0] COND_ZERO = 2'h1;
  localparam logic [1:0] COND_SIGN = 2'h2;
  localparam logic [1:0] COND_PARITY = 2'h3;
  // Clock periods per state, and state counts per instruction
  localparam logic [3:0] CLK_PER_STATE = 4'h2;
  localparam logic [3:0] ST_MOVE = 4'h5;
  localparam logic [3:0] ST_LOAD_MEM = 4'h8;
  localparam logic [3:0] ST_STORE_MEM = 4'h7;
  localparam logic [3:0] ST_LOAD_IMM = 4'h8;
  localparam logic [3:0] ST_STORE_IMM = 4'h9;
  // States of fetch cycle: states spent before a read or a register store write begins; the immediate store write waits for ST_LOAD_IMM
  localparam logic [3:0] ST_FETCH = 4'h5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Memory request carrier
  typedef struct packed {
    logic rd;
    logic wr;
    logic [13:0] addr;
    logic [7:0] wdata;
  } ildx_mem_req_t;
  // Condition flags carrier
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic parity;
  } ildx_flags_t;
endpackage

// File: hw/ildx_decoder.sv
/*
 Decoder and executor for index register load instructions of a
 byte-wide processor: moves, memory loads and stores, immediates.
 Assumes opcode and operand bytes are presented by a fetch unit on the
 same clock, and memory answers reads in the same state they are asked.
*/
`timescale 1ns/1ps
`default_nettype none
module ildx_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [7:0] operand_byte,
  input wire logic [7:0] mem_rdata,
  input wire logic [1:0] cond_sel,
  input wire ildx_pkg::ildx_flags_t flags_in,
  output logic busy,
  output logic done,
  output logic halted,
  output logic unsupported,
  output logic cond_true,
  output ildx_pkg::ildx_mem_req_t mem_req,
  output ildx_pkg::ildx_flags_t flags_out,
  output logic [63:0] reg_file
);
  ////////////////////////////////////////////////////////////////////
  // Sequencing states
  typedef enum logic [1:0] {ILDX_IDLE, ILDX_EXEC, ILDX_HALT} ildx_st_t;
  ildx_st_t state_ff, nxt_state;
  logic [7:0] regs_ff [0:7]; // Index 7 unused; M is not a register
  logic [7:0] nxt_regs [0:7];
  logic [7:0] op_ff; // Latched opcode
  logic [7:0] imm_ff; // Latched second byte
  logic [3:0] state_cnt_ff; // States executed so far
  logic phase_ff; // Clock period within a state
  logic done_ff;
  logic [3:0] last_state;
  ildx_pkg::ildx_mem_req_t mem_req_ff, nxt_mem_req;

  ////////////////////////////////////////////////////////////////////
  // Field decode of the latched opcode
  wire [1:0] grp = op_ff[ildx_pkg::GRP_LSB +: 2];
  wire [2:0] dest_field = op_ff[ildx_pkg::DEST_LSB +: 3];
  wire [2:0] src_field = op_ff[ildx_pkg::SRC_LSB +: 3];
  wire is_load = grp == ildx_pkg::GRP_LOAD;
  wire dst_m = dest_field == ildx_pkg::REG_M;
  wire src_m = src_field == ildx_pkg::REG_M;
  // Both fields 111 is the halt alias of both memory forms
  wire halt_op = is_load && dst_m && src_m;
  wire load_reg_from_mem = is_load && src_m && !dst_m;
  wire store_reg_to_mem = is_load && dst_m && !src_m;
  wire move_reg_to_reg = is_load && !dst_m && !src_m;
  wire move_same = move_reg_to_reg && dest_field == src_field;
  wire imm_form = grp == ildx_pkg::GRP_IMM &&
                  src_field == ildx_pkg::SRC_IMM;
  wire load_reg_immediate = imm_form && !dst_m;
  wire store_mem_immediate = imm_form && dst_m;
  wire known = is_load || imm_form;
  // Address from H high and L low, trimmed to the 14-bit bus
  wire [13:0] hl_addr = {regs_ff[ildx_pkg::REG_H][5:0],
                         regs_ff[ildx_pkg::REG_L]};
  // State boundary: end of the second clock period of a state
  wire state_end = state_ff == ILDX_EXEC && phase_ff;
  wire final_state = state_end && state_cnt_ff == last_state - 4'h1;
  // Memory phases start after the fetch cycle
  wire mem_phase = state_cnt_ff >= ildx_pkg::ST_FETCH;
  wire in_write = store_reg_to_mem ||
                  (store_mem_immediate &&
                   state_cnt_ff >= ildx_pkg::ST_LOAD_IMM);

  ////////////////////////////////////////////////////////////////////
  // State count per instruction form
  assign last_state = load_reg_from_mem ? ildx_pkg::ST_LOAD_MEM :
                      store_reg_to_mem ? ildx_pkg::ST_STORE_MEM :
                      load_reg_immediate ? ildx_pkg::ST_LOAD_IMM :
                      store_mem_immediate ? ildx_pkg::ST_STORE_IMM :
                      ildx_pkg::ST_MOVE;

  ////////////////////////////////////////////////////////////////////
  // Condition flag select; flags pass through, loads never alter them
  assign cond_true = cond_sel == ildx_pkg::COND_CARRY ? flags_in.carry :
                     cond_sel == ildx_pkg::COND_ZERO ? flags_in.zero :
                     cond_sel == ildx_pkg::COND_SIGN ? flags_in.sign :
                     flags_in.parity;
  assign flags_out = flags_in;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ILDX_IDLE: begin
        if (opcode_valid) begin
          nxt_state = ILDX_EXEC;
        end
      end
      ILDX_EXEC: begin
        // Halt is taken at the end of the first state
        if (halt_op && state_end) begin
          nxt_state = ILDX_HALT;
        end else if (!known && state_end) begin
          nxt_state = ILDX_IDLE;
        end else if (final_state) begin
          nxt_state = ILDX_IDLE;
        end
      end
      default: begin
        // Halt holds until reset
        nxt_state = ILDX_HALT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Register file writes, done in the last clock of the last state
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (final_state && !halt_op) begin
      if (move_reg_to_reg && !move_same) begin
        nxt_regs[dest_field] = regs_ff[src_field];
      end else if (load_reg_from_mem) begin
        nxt_regs[dest_field] = mem_rdata;
      end else if (load_reg_immediate) begin
        nxt_regs[dest_field] = imm_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory request during the read or write cycle
  always_comb begin
    nxt_mem_req = '0;
    if (state_ff == ILDX_EXEC && mem_phase && !halt_op) begin
      nxt_mem_req.addr = hl_addr;
      if (load_reg_from_mem) begin
        nxt_mem_req.rd = 1'b1;
      end else if (in_write) begin
        nxt_mem_req.wr = 1'b1;
        nxt_mem_req.wdata = store_reg_to_mem ? regs_ff[src_field] : imm_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ILDX_IDLE;
      op_ff <= ildx_pkg::RESET_BYTE;
      imm_ff <= ildx_pkg::RESET_BYTE;
      state_cnt_ff <= 4'h0;
      phase_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= final_state && !halt_op;
      if (state_ff == ILDX_IDLE && opcode_valid) begin
        op_ff <= opcode;
        imm_ff <= operand_byte;
        state_cnt_ff <= 4'h0;
        phase_ff <= 1'b0;
      end else if (state_ff == ILDX_EXEC) begin
        phase_ff <= ~phase_ff;
        if (state_end) begin
          state_cnt_ff <= state_cnt_ff + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file and memory request flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= ildx_pkg::RESET_BYTE;
      end
      mem_req_ff <= '0;
    end else begin
      regs_ff <= nxt_regs;
      mem_req_ff <= nxt_mem_req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy = state_ff == ILDX_EXEC;
  assign done = done_ff;
  assign halted = state_ff == ILDX_HALT;
  assign unsupported = state_ff == ILDX_EXEC && !known;
  assign mem_req = mem_req_ff;
  generate
    for (genvar g = 0; g < 8; g++) begin : g_rf
      assign reg_file[g*8 +: 8] = regs_ff[g];
    end
  endgenerate
endmodule
`default_nettype wire

// File: tb/ildx_mem_model.sv
/*
 Byte-wide program and data memory on the far side of the decoder.
 Assumes the registered request carrier of ildx_pkg and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ildx_mem_model (
  input wire logic clk,
  input wire ildx_pkg::ildx_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:16383]; // Eight-bit words, 14-bit space
  logic [7:0] last_ff; // Last byte driven, kept to invert when idle
  initial begin
    for (int i = 0; i < 16384; i++) ram[i] = 8'(i) ^ 8'h5a;
    last_ff = 8'h00;
  end
  // Writes land at the clock edge; reads are answered at once
  always @(posedge clk) begin
    if (mem_req.wr) ram[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd) last_ff <= ram[mem_req.addr];
  end
  // Released bus shows no stale byte, so a late sample cannot pass
  assign mem_rdata = mem_req.rd ? ram[mem_req.addr] : ~last_ff;
endmodule
`default_nettype wire

// File: tb/ildx_decoder_checker.sv
/*
 Port assertions for the index load decoder.
 Assumes binding onto ildx_decoder in a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ildx_decoder_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [1:0] cond_sel,
  input wire ildx_pkg::ildx_flags_t flags_in,
  input wire logic busy,
  input wire logic done,
  input wire logic halted,
  input wire logic cond_true,
  input wire ildx_pkg::ildx_mem_req_t mem_req,
  input wire ildx_pkg::ildx_flags_t flags_out,
  input wire logic [63:0] reg_file
);
  // Accepted request and its opcode fields
  wire take = opcode_valid && !busy && !halted;
  wire [2:0] d = opcode[5:3];
  wire [2:0] s = opcode[2:0];
  wire ld = take && opcode[7:6] == 2'h3;
  wire im = take && opcode[7:6] == 2'h0 && s == 3'h6;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  flags_keep_a: assert property (
    flags_out == flags_in) else $error("flags changed");
  cond_pick_a: assert property (
    cond_true == flags_in[2'h3 - cond_sel]) else $error("bad flag pick");
  move_time_a: assert property (
    ld && d != 3'h7 && s != 3'h7 |-> ##11 done) else $error("move time");
  load_time_a: assert property (
    ld && d != 3'h7 && s == 3'h7 |-> ##17 done) else $error("load time");
  store_time_a: assert property (
    ld && d == 3'h7 && s != 3'h7 |-> ##15 done) else $error("store time");
  imm_reg_a: assert property (
    im && d != 3'h7 |-> ##17 done) else $error("imm load time");
  imm_mem_a: assert property (
    im && d == 3'h7 |-> ##19 done) else $error("imm store time");
  halt_alias_a: assert property (
    take && opcode == 8'hff |-> ##3 halted) else $error("no halt");
  halt_hold_a: assert property (
    halted |=> halted) else $error("halt lost");
  done_pulse_a: assert property (
    done |=> !done) else $error("done too long");
  hl_addr_a: assert property (
    mem_req.wr |-> mem_req.addr == {reg_file[45:40], reg_file[55:48]})
    else $error("bad address");
  no_byte7_a: assert property (
    reg_file[63:56] == 8'h00) else $error("code 7 is no register");
  cover property (ld && d != 3'h7 && s != 3'h7);
  cover property (mem_req.wr);
  cover property (halted);
endmodule
bind ildx_decoder ildx_decoder_checker chk (.clk(clk), .reset_n(reset_n),
  .opcode(opcode), .opcode_valid(opcode_valid), .cond_sel(cond_sel),
  .flags_in(flags_in), .busy(busy), .done(done), .halted(halted),
  .cond_true(cond_true), .mem_req(mem_req), .flags_out(flags_out),
  .reg_file(reg_file));
`default_nettype wire

// File: tb/index_register_load_decoder_tb_top.sv
/*
 Self-checking bench for ildx_decoder with its memory model.
 Assumes package, decoder and memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module index_register_load_decoder_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic opcode_valid = 1'b0;
  logic [7:0] opcode = 8'h00, operand_byte = 8'h00, mem_rdata, op;
  logic [1:0] cond_sel = 2'h0;
  ildx_pkg::ildx_flags_t flags_in = 4'h0, flags_out;
  ildx_pkg::ildx_mem_req_t mem_req;
  logic busy, done, halted, unsupported, cond_true;
  logic [63:0] reg_file;
  logic [7:0] m [0:7]; // Expected register file, code 7 stays zero
  int n_fail = 0, n_checks = 0, seed = 32'h1505d841;
  always #2 clk = ~clk;
  ildx_decoder dut (.clk(clk), .reset_n(reset_n), .opcode(opcode),
    .opcode_valid(opcode_valid), .operand_byte(operand_byte),
    .mem_rdata(mem_rdata), .cond_sel(cond_sel), .flags_in(flags_in),
    .busy(busy), .done(done), .halted(halted), .unsupported(unsupported),
    .cond_true(cond_true), .mem_req(mem_req), .flags_out(flags_out),
    .reg_file(reg_file));
  ildx_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int states(input logic [7:0] o);
    if (o[7:6] == 2'h0) return o[5:3] == 3'h7 ? 9 : 8;
    if (o[2:0] == 3'h7) return 8;
    return o[5:3] == 3'h7 ? 7 : 5;
  endfunction
  function automatic logic [63:0] regs();
    logic [63:0] r;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = m[i];
    return r;
  endfunction
  // Present one request; it is taken at the rising edge that follows
  task automatic give(input logic [7:0] o, b2);
    @(negedge clk);
    opcode = o;
    operand_byte = b2;
    opcode_valid = 1'b1;
    flags_in = 4'($random(seed));
    cond_sel = cond_sel + 2'h1;
    @(posedge clk);
  endtask
  task automatic run(input logic [7:0] o, b2);
    logic [13:0] a;
    logic [7:0] v;
    int n;
    a = {m[5][5:0], m[6]};
    v = o[7:6] == 2'h0 ? b2 : (o[2:0] == 3'h7 ? mem.ram[a] : m[o[2:0]]);
    give(o, b2);
    n = 0;
    do begin
      @(negedge clk);
      opcode_valid = 1'b0;
      n++;
    end while (done !== 1'b1 && n < 40);
    // Done rises 2N edges after the take; the falling edge just after
    // that is the (2N+1)th one the loop has counted
    chk(n, 2 * states(o) + 1);
    if (o[5:3] == 3'h7) chk(mem.ram[a], v);
    else m[o[5:3]] = v;
    chk(reg_file, regs());
    chk(flags_out, flags_in);
    chk(cond_true, flags_in[2'h3 - cond_sel]);
    $display("op %h done", o);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) m[i] = 8'h00;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    // Corners: high H bits dropped, both immediates, H:L load and store
    run(8'h2e, 8'hff);
    run(8'h36, 8'h80);
    run(8'h3e, 8'ha5);
    run(8'hc7, 8'h00);
    run(8'hf8, 8'h00);
    run(8'hc9, 8'h00);
    // Opcode outside both load groups: flagged, no done, nothing written
    give(8'h80, 8'h00);
    @(negedge clk) opcode_valid = 1'b0;
    chk(unsupported, 1'b1);
    chk(busy, 1'b1);
    repeat (20) @(negedge clk) chk(done, 1'b0);
    chk(busy, 1'b0);
    chk(unsupported, 1'b0);
    chk(reg_file, regs());
    $display("op 80 done");
    repeat (30) begin
      op = 8'($random(seed));
      if (op[7:6] != 2'h3) op = {2'h0, op[5:3], 3'h6};
      if (op == 8'hff) op = 8'hc0;
      run(op, 8'($random(seed)));
    end
    // Halt alias, then a request that must be ignored while halted
    give(8'hff, 8'h00);
    repeat (3) @(negedge clk) opcode_valid = 1'b0;
    chk(halted, 1'b1);
    give(8'hc8, 8'h00);
    repeat (12) @(negedge clk) opcode_valid = 1'b0;
    chk(reg_file, regs());
    // Reset in mid-run clears the halt and the registers
    reset_n = 1'b0;
    for (int i = 0; i < 8; i++) m[i] = 8'h00;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    run(8'hd5, 8'h00);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #40000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
